// ---- dv/tb.sv ----
// self-checking testbench for the branch-if-zero decode and execute block
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic instrValid = 1'b0;
    logic zeroFlag = 1'b0;
    logic [15:0] instrWord = 16'h0000;
    logic [20:0] pcNow = 21'h000000;
    logic isBranch, flushCycle, instrDone, flagWrite;
    logic [1:0] phase;
    bzx_pkg::bzx_pcwr_t pcWrite;
    int nMismatch = 0;
    int nChecks = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // clock at 200 MHz and the unit under test
    always #2.5 sys_clk = ~sys_clk;

    bzx_branch_if_zero #(.PC_WIDTH(21)) dut (.sys_clk(sys_clk), .nrst(nrst),
        .instrValid(instrValid), .instrWord(instrWord), .pcNow(pcNow), .zeroFlag(zeroFlag),
        .isBranch(isBranch), .phase(phase), .flushCycle(flushCycle), .instrDone(instrDone),
        .flagWrite(flagWrite), .pcWrite(pcWrite));

    ////////////////////////////////////////////////////////////////////////////////
    // shared helpers: compare, advance one clock, verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp) begin
            nMismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // inputs move 1 ns after the edge so the design never races the bench
    task automatic step;
        @(posedge sys_clk);
        #1;
        chk(flagWrite, 32'h0);
    endtask

    task automatic complete_run;
        if (nMismatch == 0 && nChecks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // one word through a full cycle; expectations worked out from the encoding
    task automatic issue(input logic [15:0] w, input logic z, input logic [20:0] pc);
        logic isbr, tk;
        logic [20:0] tgt;
        int i;
        isbr = (w[15:8] === 8'he0);
        tk = isbr && z;
        tgt = pc + {{12{w[7]}}, w[7:0], 1'b0};
        i = 0;
        while (phase !== 2'h0 && i < 8) begin
            step();
            i++;
        end
        instrValid = 1'b1;
        instrWord = w;
        zeroFlag = z;
        pcNow = pc;
        step();
        instrValid = 1'b0;
        chk(isBranch, isbr);
        step();
        step();
        chk(phase, 2'h3);
        chk(pcWrite.write, tk);
        if (tk) chk(pcWrite.value, tgt);
        chk(instrDone, isbr && !tk);
        if (!tk) chk(flushCycle, 1'b0);
        // during the idle cycle a fresh branch word is offered and must be ignored
        for (i = 0; tk && i < 4; i++) begin
            step();
            instrValid = (i == 0);
            instrWord = 16'he001;
            zeroFlag = 1'b1;
            chk(flushCycle, 1'b1);
            chk(isBranch, 1'h0);
            chk(pcWrite.write, 1'b0);
            chk(instrDone, i == 3);
        end
        instrValid = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic taken_forward;
        issue(16'he005, 1'b1, 21'h000102);
    endtask

    task automatic taken_back_limits;
        issue(16'he080, 1'b1, 21'h001000);
        issue(16'he07f, 1'b1, 21'h1ffffe);
        issue(16'he0ff, 1'b1, 21'h000000);
    endtask

    task automatic not_taken_back_to_back;
        issue(16'he010, 1'b0, 21'h000200);
        issue(16'he080, 1'b0, 21'h000204);
    endtask

    task automatic other_opcodes;
        issue(16'he105, 1'b1, 21'h000300);
        issue(16'h6005, 1'b1, 21'h000302);
        issue(16'he005, 1'b1, 21'h000304);
    endtask

    // reset lands in the last phase of an idle cycle; the block must come back clean
    task automatic reset_mid_run;
        issue(16'he002, 1'b1, 21'h000400);
        nrst = 1'b0;
        step();
        chk(phase, 2'h0);
        chk(flushCycle, 1'h0);
        chk(pcWrite.write, 1'h0);
        chk(instrDone, 1'h0);
        step();
        nrst = 1'b1;
        issue(16'he0fe, 1'b1, 21'h000500);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence and a watchdog well beyond the expected run length
    initial begin
        repeat (5) @(posedge sys_clk);
        #1;
        nrst = 1'b1;
        taken_forward();
        taken_back_limits();
        not_taken_back_to_back();
        other_opcodes();
        reset_mid_run();
        complete_run();
    end

    initial begin
        #20000;
        nMismatch++;
        complete_run();
    end
endmodule
`default_nettype wire

// ---- rtl/bzx_branch_if_zero.sv ----
// branch-if-zero instruction decode and execute logic with its phase sequencing
// What this block does
// - recognise a one-word instruction whose upper eight bits are 1110 0000
// - branch only when the zero flag is one; otherwise continue sequentially
// - treat the literal as two's complement, double it, add to the program counter
// - target is instruction address plus two plus twice the offset
// - one cycle when not taken, two when taken; the second is idle
// - decode in phase one, read literal phase two, process three, write pc four
// - leave every status flag unchanged, taken or not
`timescale 1ns/10ps
`default_nettype none
module bzx_branch_if_zero #(
    parameter int PC_WIDTH = 21
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic instrValid,
    input wire logic [15:0] instrWord,
    input wire logic [PC_WIDTH-1:0] pcNow,
    input wire logic zeroFlag,
    output logic isBranch,
    output logic [1:0] phase,
    output logic flushCycle,
    output logic instrDone,
    output logic flagWrite,
    output bzx_pkg::bzx_pcwr_t pcWrite
);
    // elaboration checks: the pc write struct fixes the pc width, and the
    // doubled offset needs room above the sign bit of the literal
    if (PC_WIDTH != bzx_pkg::PC_BITS) begin : g_pcWidthBad
        $error("PC_WIDTH must match the pc write struct width");
    end
    if (PC_WIDTH <= bzx_pkg::OFFSET_WIDTH) begin : g_pcNarrow
        $error("PC_WIDTH must be wider than the offset literal");
    end

    ////////////////////////////////////////////////////////////////////////////
    // phase counter and execute state
    bzx_pkg::bzx_phase_t phaseNow;
    bzx_pkg::bzx_state_t state;
    bzx_pkg::bzx_state_t next_state;
    logic [15:0] instrHeld;
    logic [7:0] literal;
    logic takenHeld;

    // phases cycle freely, one per clock
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            phaseNow <= bzx_pkg::bzx_phase_t'(bzx_pkg::PHASE_RESET);
        end else begin
            phaseNow <= bzx_pkg::bzx_phase_t'(phaseNow + 2'h1);
        end
    end

    wire atOne = (phaseNow == bzx_pkg::BZX_PHASE_ONE);
    wire atTwo = (phaseNow == bzx_pkg::BZX_PHASE_TWO);
    wire atThree = (phaseNow == bzx_pkg::BZX_PHASE_THREE);
    wire atFour = (phaseNow == bzx_pkg::BZX_PHASE_FOUR);

    ////////////////////////////////////////////////////////////////////////////
    // decode: opcode match on the held word
    wire opMatch = (instrHeld[bzx_pkg::OPCODE_MSB:bzx_pkg::OPCODE_LSB]
        == bzx_pkg::OPCODE_VALUE);
    wire decodeHit = (state == bzx_pkg::BZX_EXEC) && opMatch;

    // instruction latched in phase one; ignored during the idle refill cycle
    // a word not marked valid is held as zero, which never matches the opcode
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            instrHeld <= 16'h0000;
        end else if (atOne && state == bzx_pkg::BZX_EXEC) begin
            instrHeld <= instrValid ? instrWord : 16'h0000;
        end
    end

    // literal read in phase two, zero flag sampled there too
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            literal <= 8'h00;
            takenHeld <= 1'b0;
        end else if (atTwo) begin
            literal <= instrHeld[bzx_pkg::OFFSET_MSB:bzx_pkg::OFFSET_LSB];
            takenHeld <= decodeHit && zeroFlag;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // process data in phase three: sign-extend, double, add to advanced pc
    // pcNow is already past this instruction, so +2 is implicit
    wire [PC_WIDTH-1:0] offsetExt = {{(PC_WIDTH-bzx_pkg::OFFSET_WIDTH){literal[7]}}, literal};
    wire [PC_WIDTH-1:0] offsetX2 = {offsetExt[PC_WIDTH-2:0], 1'b0};
    wire [PC_WIDTH-1:0] nextTarget = pcNow + offsetX2;
    // the strobe is decided in phase three so that it stands through phase four;
    // the state term keeps the refill cycle from ever writing the pc
    wire writeNow = atThree && takenHeld && (state == bzx_pkg::BZX_EXEC);

    ////////////////////////////////////////////////////////////////////////////
    // state: a taken branch adds one idle cycle after phase four
    // the idle cycle reuses the free-running phases, so it lasts exactly four clocks
    always_comb begin
        next_state = state;
        unique case (state)
            bzx_pkg::BZX_EXEC: begin
                if (atFour && takenHeld) begin
                    next_state = bzx_pkg::BZX_FLUSH;
                end
            end
            bzx_pkg::BZX_FLUSH: begin
                if (atFour) begin
                    next_state = bzx_pkg::BZX_EXEC;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state <= bzx_pkg::BZX_EXEC;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs: pc write in phase four, status flags never written
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            pcWrite <= '0;
        end else begin
            pcWrite.write <= writeNow;
            if (atThree) begin
                pcWrite.value <= nextTarget;
            end
        end
    end

    assign flagWrite = 1'b0;
    assign phase = phaseNow;
    assign flushCycle = (state == bzx_pkg::BZX_FLUSH);
    // masked in phase one, where the held word still belongs to the last instruction
    assign isBranch = decodeHit && !atOne;
    // done at the end of phase four of the last cycle of the instruction
    assign instrDone = atFour && ((state == bzx_pkg::BZX_EXEC && opMatch && !takenHeld)
        || state == bzx_pkg::BZX_FLUSH);

    ////////////////////////////////////////////////////////////////////////////
    // checks: all on sys_clk and held off while nrst is low
    // a branch word met at the phase-two edge with the zero flag set
    sequence takenSeen_s;
        atTwo && decodeHit && zeroFlag;
    endsequence
    // the same word met with the zero flag clear
    sequence notTakenSeen_s;
        atTwo && decodeHit && !zeroFlag;
    endsequence
    // one whole refill cycle, all four phases idle
    sequence idleCycle_s;
        flushCycle [*4];
    endsequence
    // one whole cycle with no refill
    sequence noIdle_s;
        !flushCycle [*4];
    endsequence

    // taken: no idle in its own phase four, then one whole idle cycle
    taken_flush_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        takenSeen_s |-> ##2 !flushCycle ##1 idleCycle_s)
        else $error("taken branch did not add one idle cycle");
    // untaken: no pc write and no idle cycle
    nottaken_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        notTakenSeen_s |-> ##2 !pcWrite.write ##1 noIdle_s)
        else $error("untaken branch wrote pc or idled");
    // taken: done only at the end of the idle cycle, two cycles in all
    taken_done_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        takenSeen_s |-> ##2 !instrDone ##4 instrDone)
        else $error("taken branch finished at the wrong time");
    // untaken: done in phase four of its only cycle
    untaken_done_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        notTakenSeen_s |-> ##2 instrDone)
        else $error("untaken branch did not finish in one cycle");

    // the pc is written in phase four only
    pc_phase_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        pcWrite.write |-> atFour)
        else $error("pc written outside phase four");
    // done marks the end of a cycle, so it only shows in phase four
    done_phase_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        instrDone |-> atFour)
        else $error("instruction done outside phase four");
    // phases follow one another, one per clock, wrapping after phase four
    phase_step_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        1'h1 |=> phase == $past(phase) + 2'h1)
        else $error("phase did not advance by one");

    // target: advanced pc of phase three plus twice the signed literal
    target_val_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        takenSeen_s ##1 1'h1 |=> pcWrite.write && pcWrite.value == PC_WIDTH'($past(pcNow)
            + {{(PC_WIDTH-9){instrHeld[7]}}, instrHeld[7:0], 1'h0}))
        else $error("branch target wrong");
    // only a word matching the opcode can lead to a pc write
    decode_hit_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        pcWrite.write |-> $past(instrHeld[15:8], 2) == 8'he0)
        else $error("pc written for a non-branch word");
    // the doubled offset carries the literal's signed value times two
    lit_sign_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        atThree |-> $signed(offsetX2) == $signed(literal) * 2)
        else $error("literal not sign-extended and doubled");

    // status flags: no write request ever leaves the block
    flags_kept_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        !flagWrite)
        else $error("status flag write requested");
    // the refill cycle never writes the pc
    flush_nowrite_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        flushCycle && atThree |=> !pcWrite.write)
        else $error("idle cycle performed a pc write");
    // a word offered during refill is refused, so no branch shows there
    idle_quiet_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        flushCycle |-> !isBranch)
        else $error("branch decoded during the idle cycle");
endmodule
`default_nettype wire

// ---- rtl/bzx_pkg.sv ----
// package of constants and types for the branch-if-zero decode and execute block
package bzx_pkg;
    // opcode field: upper eight bits of the instruction word
    localparam logic [7:0] OPCODE_VALUE = 8'he0;
    localparam int OPCODE_MSB = 15;
    localparam int OPCODE_LSB = 8;
    // offset literal: eight low bits of the instruction word
    localparam int OFFSET_MSB = 7;
    localparam int OFFSET_LSB = 0;
    localparam int OFFSET_WIDTH = 8;
    // bytes per instruction word, the fetch increment
    localparam int WORD_BYTES = 2;
    // phase counter reset value
    localparam logic [1:0] PHASE_RESET = 2'h0;
    // program counter width carried by the pc write struct
    localparam int PC_BITS = 21;

    // four-phase instruction cycle
    typedef enum logic [1:0] {
        BZX_PHASE_ONE = 2'b00,
        BZX_PHASE_TWO = 2'b01,
        BZX_PHASE_THREE = 2'b10,
        BZX_PHASE_FOUR = 2'b11
    } bzx_phase_t;

    // execute state: first cycle or idle refill cycle
    typedef enum logic [0:0] {
        BZX_EXEC = 1'b0,
        BZX_FLUSH = 1'b1
    } bzx_state_t;

    // program counter write request
    typedef struct packed {
        logic write;
        logic [PC_BITS-1:0] value;
    } bzx_pcwr_t;
endpackage
